// ==== common/usart_regs_pkg.sv ====
/*
  package for the serial port character, baud and timing register block:
  register offsets, field positions, reset values, carrier structs.
  assumes a 32-bit classic wishbone slave, byte addressed, word aligned.
*/
package usart_regs_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_RX_HOLDING  = 8'h00; // read only
  localparam logic [7:0] OFF_TX_HOLDING  = 8'h04; // write only
  localparam logic [7:0] OFF_BAUD_DIV    = 8'h08;
  localparam logic [7:0] OFF_RX_TIMEOUT  = 8'h0c;
  localparam logic [7:0] OFF_TX_GUARD    = 8'h10;
  localparam logic [7:0] OFF_ISO_RATIO   = 8'h14;
  localparam logic [7:0] OFF_MODE        = 8'h18;
  localparam logic [7:0] OFF_CONTROL     = 8'h1c;
  localparam logic [7:0] OFF_STATUS      = 8'h20;

  // field positions
  localparam int CHAR_W         = 9;  // character bits 0..8
  localparam int SYNC_BIT       = 15; // command/data sync bit
  localparam int MODE_SYNC_BIT  = 0;  // synchronous mode
  localparam int MODE_OVER_BIT  = 1;  // eight-times oversampling
  localparam int MODE_ISO_BIT   = 2;  // smart-card mode
  localparam int CTRL_STTO_BIT  = 0;  // restart time-out command
  localparam int ST_RX_CHAR_READY_BIT   = 0;
  localparam int ST_TX_HOLDING_FREE_BIT   = 1;
  localparam int ST_TOUT_BIT    = 8;
  localparam int ST_CTS_BIT     = 23;
  localparam int ISO_RATIO_W    = 11;

  // reset values
  localparam logic [10:0] ISO_RATIO_RST = 11'h174;
  localparam logic [15:0] BAUD_DIV_RST  = 16'h0000;
  localparam logic [15:0] TIMEOUT_RST   = 16'h0000;
  localparam logic [7:0]  GUARD_RST     = 8'h00;

  // oversampling factors
  localparam logic [4:0] OVS_16 = 5'h10;
  localparam logic [4:0] OVS_8  = 5'h08;
  localparam logic [4:0] OVS_1  = 5'h01;

  // character with its sync bit
  typedef struct packed {
    logic                  cmd;  // 1 command, 0 data
    logic [CHAR_W-1:0]     data;
  } char_t;

  // mode bits set by software
  typedef struct packed {
    logic iso;
    logic over;
    logic sync;
  } mode_t;

endpackage

// ==== src/bit_period_counter.sv ====
/*
  counter that counts whole bit periods up to a programmed limit.
  assumes bit_tick_i is a one-cycle pulse, one per bit period.
*/
module bit_period_counter (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        restart_i,  // start counting again from zero
  input  wire logic        bit_tick_i, // one pulse per bit period
  input  wire logic [15:0] limit_i,    // 0 disables
  output logic             done_o      // level: limit reached
);

  // counter state
  typedef struct packed {
    logic [15:0] cnt;
    logic        run;
    logic        done;
  } cnt_state_t;

  cnt_state_t state_ff;  // registered state
  cnt_state_t nxt_state; // next state

  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    if (restart_i) begin
      nxt_state.cnt  = 16'h0000;
      nxt_state.run  = (limit_i != 16'h0000);
      nxt_state.done = 1'b0;
    end else if (limit_i == 16'h0000) begin
      // disabled: never done
      nxt_state.run  = 1'b0;
      nxt_state.done = 1'b0;
    end else if (state_ff.run && bit_tick_i) begin
      nxt_state.cnt = state_ff.cnt + 16'h0001;
      if (nxt_state.cnt >= limit_i) begin
        nxt_state.run  = 1'b0;
        nxt_state.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign done_o = state_ff.done;

endmodule

// ==== src/usart_char_baud_timing_regs.sv ====
/*
  serial port character holding registers, baud divisor, receiver
  time-out, transmitter timeguard and smart-card clock ratio, reached
  over a classic wishbone slave.
  assumes the frame shifters outside use tx_load_o / rx_valid_i and the
  bit tick; cts_i is synchronous to clk_i.
*/
// The placing of the registers and register access over Wishbone were decided locally.
// Functional notes
// - status bit mirrors clear-to-send input level
// - received character readable in bits 0..8
// - bit 15 marks last received as command
// - written character sent after current one
// - bit 15 of write selects command sync
// - async x16: clock / 16 / divisor, 0 off
// - async x8: clock / 8 / divisor
// - synchronous: clock / divisor, no oversampling
// - time-out value times bit period, 0 off
// - timeguard idle bits between characters, 0 off
// - smart-card ratio zero: no baud output
// - smart-card: clock / divisor / ratio, reset 0x174
// - time-out flag after restart, low when off
// - holding-free low while character waits
module usart_char_baud_timing_regs (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [7:0]                   adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  // line side
  input  wire logic                         cts_i,
  // receive shifter
  input  wire logic                         rx_valid_i,
  input  wire usart_regs_pkg::char_t        rx_char_i,
  input  wire logic                         rx_activity_i,
  // transmit shifter
  input  wire logic                         tx_shifter_idle_i,
  output logic                              tx_load_o,
  output usart_regs_pkg::char_t             tx_char_o,
  // baud timing
  output logic                              sample_tick_o,
  output logic                              bit_tick_o,
  output logic                              timeout_o
);

  // all module state except the time-out counter, which is held in u_timeout
  typedef struct packed {
    logic [15:0]              baud_divisor;
    logic [15:0]              rx_timeout_value;
    logic [7:0]               tx_guard_value;
    logic [10:0]              smartcard_clock_ratio;
    usart_regs_pkg::mode_t    mode;
    usart_regs_pkg::char_t    received_char;
    logic                     rx_char_ready;
    usart_regs_pkg::char_t    char_to_send;
    logic                     tx_holding_free;
    logic                     tx_load;
    usart_regs_pkg::char_t    tx_char;
    logic [7:0]               guard_cnt;
    logic                     guard_busy;
    logic [15:0]              div_cnt;
    logic [4:0]               ovs_cnt;
    logic [10:0]              ratio_cnt;
    logic                     sample_tick;
    logic                     bit_tick;
    logic                     cts;
    logic                     ack;
    logic [31:0]              rdata;
  } regs_state_t;

  regs_state_t state_ff;  // registered state
  regs_state_t nxt_state; // next state

  logic        bus_req;     // valid access this cycle
  logic        wr_acc;      // write strobe
  logic        rd_acc;      // read strobe
  logic        restart_to;  // time-out restart command
  logic        to_done;     // time-out reached
  logic [31:0] rd_mux;      // read data before register

  // oversampling factor for the active mode
  function automatic logic [4:0] ovs_factor(usart_regs_pkg::mode_t m);
    if (m.sync || m.iso) begin
      ovs_factor = usart_regs_pkg::OVS_1;
    end else if (m.over) begin
      ovs_factor = usart_regs_pkg::OVS_8;
    end else begin
      ovs_factor = usart_regs_pkg::OVS_16;
    end
  endfunction

  // merge write data into a word under byte lanes
  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] wd,
                                        logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // bus strobes; ack drops the cycle after it is given
  // a request is taken only while ack is low: one access, one ack
  assign bus_req    = cyc_i && stb_i && !state_ff.ack;
  assign wr_acc     = bus_req && we_i;
  assign rd_acc     = bus_req && !we_i;
  assign restart_to = wr_acc && (adr_i == usart_regs_pkg::OFF_CONTROL)
                      && sel_i[0]
                      && dat_i[usart_regs_pkg::CTRL_STTO_BIT];

  // read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (adr_i)
      usart_regs_pkg::OFF_RX_HOLDING: begin
        rd_mux[usart_regs_pkg::CHAR_W-1:0] =
          state_ff.received_char.data;
        rd_mux[usart_regs_pkg::SYNC_BIT] =
          state_ff.received_char.cmd;
      end
      usart_regs_pkg::OFF_BAUD_DIV:   rd_mux[15:0] = state_ff.baud_divisor;
      usart_regs_pkg::OFF_RX_TIMEOUT:
        rd_mux[15:0] = state_ff.rx_timeout_value;
      usart_regs_pkg::OFF_TX_GUARD:   rd_mux[7:0] = state_ff.tx_guard_value;
      usart_regs_pkg::OFF_ISO_RATIO:
        rd_mux[10:0] = state_ff.smartcard_clock_ratio;
      usart_regs_pkg::OFF_MODE:       rd_mux[2:0] = state_ff.mode;
      usart_regs_pkg::OFF_STATUS: begin
        rd_mux[usart_regs_pkg::ST_RX_CHAR_READY_BIT] = state_ff.rx_char_ready;
        rd_mux[usart_regs_pkg::ST_TX_HOLDING_FREE_BIT] = state_ff.tx_holding_free;
        rd_mux[usart_regs_pkg::ST_TOUT_BIT]  = to_done;
        rd_mux[usart_regs_pkg::ST_CTS_BIT]   = state_ff.cts;
      end
      // unmapped and write-only read as zero
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next-state logic
  always_comb begin
    logic [31:0] w;
    logic        div_wrap;
    logic        ovs_wrap;
    w         = 32'h0000_0000;
    div_wrap  = 1'b0;
    ovs_wrap  = 1'b0;
    nxt_state = state_ff;
    nxt_state.ack         = bus_req;
    nxt_state.tx_load     = 1'b0;
    nxt_state.sample_tick = 1'b0;
    nxt_state.bit_tick    = 1'b0;
    nxt_state.cts         = cts_i;
    if (rd_acc) begin
      nxt_state.rdata = rd_mux;
    end

    // register writes
    if (wr_acc) begin
      case (adr_i)
        usart_regs_pkg::OFF_BAUD_DIV: begin
          w = merge({16'h0000, state_ff.baud_divisor}, dat_i, sel_i);
          nxt_state.baud_divisor = w[15:0];
        end
        usart_regs_pkg::OFF_RX_TIMEOUT: begin
          w = merge({16'h0000, state_ff.rx_timeout_value}, dat_i, sel_i);
          nxt_state.rx_timeout_value = w[15:0];
        end
        usart_regs_pkg::OFF_TX_GUARD: begin
          if (sel_i[0]) begin
            nxt_state.tx_guard_value = dat_i[7:0];
          end
        end
        usart_regs_pkg::OFF_ISO_RATIO: begin
          w = merge({21'h00000, state_ff.smartcard_clock_ratio},
                    dat_i, sel_i);
          nxt_state.smartcard_clock_ratio = w[10:0];
        end
        usart_regs_pkg::OFF_MODE: begin
          if (sel_i[0]) begin
            nxt_state.mode = dat_i[2:0];
          end
        end
        default: begin
          // control and transmit holding: handled elsewhere; status, receive holding and unmapped: ignored
        end
      endcase
    end

    // transmit holding write; a write while full overwrites
    if (wr_acc && adr_i == usart_regs_pkg::OFF_TX_HOLDING) begin
      nxt_state.char_to_send.data =
        dat_i[usart_regs_pkg::CHAR_W-1:0];
      nxt_state.char_to_send.cmd =
        dat_i[usart_regs_pkg::SYNC_BIT];
      nxt_state.tx_holding_free = 1'b0;
    end else if (!state_ff.tx_holding_free && tx_shifter_idle_i
                 && !state_ff.guard_busy && !state_ff.tx_load) begin
      // hand over once the shifter and the guard time are done;
      // the load term keeps a second hand-over off the edge at which
      // the shifter still shows idle from before the first load
      nxt_state.tx_load         = 1'b1;
      nxt_state.tx_char         = state_ff.char_to_send;
      nxt_state.tx_holding_free = 1'b1;
      nxt_state.guard_cnt       = 8'h00;
      nxt_state.guard_busy      = 1'b0;
    end

    // timeguard: idle bit periods after each character
    // only idle ticks count, so the shift time never eats into the gap
    if (state_ff.tx_load && state_ff.tx_guard_value != 8'h00) begin
      nxt_state.guard_busy = 1'b1;
      nxt_state.guard_cnt  = 8'h00;
    end else if (state_ff.guard_busy && tx_shifter_idle_i
                 && state_ff.bit_tick) begin
      nxt_state.guard_cnt = state_ff.guard_cnt + 8'h01;
      if (nxt_state.guard_cnt >= state_ff.tx_guard_value) begin
        nxt_state.guard_busy = 1'b0;
      end
    end

    // receive holding: set wins over the read clear
    if (rx_valid_i) begin
      nxt_state.received_char = rx_char_i;
      nxt_state.rx_char_ready = 1'b1;
    end else if (rd_acc && adr_i == usart_regs_pkg::OFF_RX_HOLDING) begin
      nxt_state.rx_char_ready = 1'b0;
    end

    // baud generator: divisor, then ratio or oversampling
    // a disabled generator parks every counter, so a new setting
    // starts from a clean phase instead of a stale count
    if (state_ff.baud_divisor == 16'h0000 ||
        (state_ff.mode.iso &&
         state_ff.smartcard_clock_ratio == 11'h000)) begin
      // clock disabled, no output
      nxt_state.div_cnt   = 16'h0000;
      nxt_state.ovs_cnt   = 5'h00;
      nxt_state.ratio_cnt = 11'h000;
    end else begin
      div_wrap = (state_ff.div_cnt >= state_ff.baud_divisor - 16'h0001);
      nxt_state.div_cnt = div_wrap ? 16'h0000
                                   : state_ff.div_cnt + 16'h0001;
      if (div_wrap) begin
        if (state_ff.mode.iso) begin
          // smart-card clock divided by the ratio
          ovs_wrap = (state_ff.ratio_cnt >=
                      state_ff.smartcard_clock_ratio - 11'h001);
          nxt_state.ratio_cnt = ovs_wrap ? 11'h000
                                         : state_ff.ratio_cnt + 11'h001;
          nxt_state.sample_tick = ovs_wrap;
        end else begin
          nxt_state.sample_tick = 1'b1;
          ovs_wrap = (state_ff.ovs_cnt >=
                      ovs_factor(state_ff.mode) - 5'h01);
          nxt_state.ovs_cnt = ovs_wrap ? 5'h00 : state_ff.ovs_cnt + 5'h01;
        end
        nxt_state.bit_tick = ovs_wrap;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
      state_ff.baud_divisor          <= usart_regs_pkg::BAUD_DIV_RST;
      state_ff.rx_timeout_value      <= usart_regs_pkg::TIMEOUT_RST;
      state_ff.tx_guard_value        <= usart_regs_pkg::GUARD_RST;
      state_ff.smartcard_clock_ratio <= usart_regs_pkg::ISO_RATIO_RST;
      state_ff.tx_holding_free       <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // receiver time-out in bit periods after a restart
  bit_period_counter u_timeout (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .restart_i  (restart_to || rx_activity_i),
    .bit_tick_i (state_ff.bit_tick),
    .limit_i    (state_ff.rx_timeout_value),
    .done_o     (to_done)
  );

  // outputs
  assign dat_o         = state_ff.rdata;
  assign ack_o         = state_ff.ack;
  assign tx_load_o     = state_ff.tx_load;
  assign tx_char_o     = state_ff.tx_char;
  assign sample_tick_o = state_ff.sample_tick;
  assign bit_tick_o    = state_ff.bit_tick;
  assign timeout_o     = to_done;

endmodule

// ==== testbench/serial_side_model.sv ====
/* model of the frame shifters beyond the register block.
   assumes loads are one-cycle pulses on the rising clock edge. */
module serial_side_model (
  input  wire logic                  clk_i,
  input  wire logic                  load_i,
  input  wire usart_regs_pkg::char_t char_i,
  output logic                       idle_o,
  output logic                       valid_o,
  output usart_regs_pkg::char_t      char_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int                    busy_cycles = 3; // shift time, bench may stretch
  int                    left        = 0;
  usart_regs_pkg::char_t sent_q[$];       // characters taken for sending
  initial begin
    idle_o  = 1'b1;
    valid_o = 1'b0;
    char_o  = 10'h155;
  end
  // shifter takes a char on load, then stays busy a while
  always @(posedge clk_i) begin
    if (load_i === 1'b1) begin
      sent_q.push_back(char_i);
      left = busy_cycles;
    end else if (left > 0) begin
      left--;
    end
    idle_o <= (left == 0) && (load_i !== 1'b1);
  end
  // deliver one received char; data does not linger after the pulse
  task send(input usart_regs_pkg::char_t c);
    @(posedge clk_i);
    char_o  <= c;
    valid_o <= 1'b1;
    @(posedge clk_i);
    valid_o <= 1'b0;
    char_o  <= ~c;
  endtask
endmodule

// ==== testbench/testbench.sv ====
/* self-checking bench for the serial port register block.
   assumes the checker and the serial side model compile before it. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  cyc_i = 1'b0;
  logic                  stb_i = 1'b0;
  logic                  we_i  = 1'b0;
  logic                  cts_i = 1'b0;
  logic [7:0]            adr_i = 8'h00;
  logic [3:0]            sel_i = 4'h0;
  logic [31:0]           dat_i = 32'h0;
  logic [31:0]           dat_o, q, v;
  logic                  ack_o, rx_valid_i, tx_idle_i, tx_load_o;
  logic                  sample_tick_o, bit_tick_o, timeout_o;
  usart_regs_pkg::char_t rx_char_i, tx_char_o, c;
  int                    miscompares = 0;
  int                    n_compared  = 0;
  int                    cycles      = 0;
  int                    seed, p, k;
  int                    gap         = 0; // bit ticks between two loads
  int                    nt          = 0; // bit ticks since last load
  logic [31:0]           txq[$];  // expected outgoing words
  logic [7:0]            offs[4] = '{8'h08, 8'h0c, 8'h10, 8'h14};
  logic [31:0]           msk[4]  = '{32'hffff, 32'hffff, 32'hff, 32'h7ff};
  int                    md[4]   = '{0, 2, 1, 4};  // x16, x8, sync, iso
  int                    dv[4]   = '{3, 3, 5, 2};
  int                    ex[4]   = '{48, 24, 5, 6}; // clocks per bit

  usart_char_baud_timing_regs dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cts_i(cts_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
    .rx_activity_i(1'b0), .tx_shifter_idle_i(tx_idle_i),
    .tx_load_o(tx_load_o), .tx_char_o(tx_char_o),
    .sample_tick_o(sample_tick_o), .bit_tick_o(bit_tick_o),
    .timeout_o(timeout_o));
  serial_side_model m (.clk_i(clk_i), .load_i(tx_load_o),
    .char_i(tx_char_o), .idle_o(tx_idle_i), .valid_o(rx_valid_i),
    .char_o(rx_char_i));

  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // bit ticks seen between two loads, for the timeguard check
  always @(posedge clk_i) begin
    if (tx_load_o === 1'b1) begin
      gap = nt;
      nt  = 0;
    end else if (bit_tick_o === 1'b1) begin
      nt++;
    end
  end
  // one classic cycle; request held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task st();
    wb(1'b0, usart_regs_pkg::OFF_STATUS, 32'h0);
  endtask
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmpn(input string n, input int e, input int g);
    cmp(n, e, g);
  endtask
  // clocks between two bit ticks
  task per();
    p = 0;
    do @(posedge clk_i); while (bit_tick_o !== 1'b1);
    do begin
      @(posedge clk_i);
      p++;
    end while (bit_tick_o !== 1'b1);
  endtask
  // ticks seen over a fixed window
  task nticks();
    k = 0;
    repeat (200) begin
      @(posedge clk_i);
      if (bit_tick_o === 1'b1 || sample_tick_o === 1'b1) k++;
    end
  endtask
  task finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    seed = 32'h40bc;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset image, unmapped read
    wb(1'b0, usart_regs_pkg::OFF_ISO_RATIO, 32'h0);
    cmp("ratio reset", 32'h174, q);
    st();
    cmp("status reset", 32'h2, q);
    wb(1'b0, 8'h24, 32'h0);
    cmp("unmapped", 32'h0, q);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wb(1'b1, offs[i], v);
      wb(1'b0, offs[i], 32'h0);
      cmp("reg rw", v & msk[i], q);
    end
    for (int i = 0; i < 2; i++) begin
      cts_i <= i[0];
      st();
      cmp("cts", {31'h0, i[0]}, {31'h0, q[23]});
    end
    $display("register test done");
    repeat (3) begin
      v = $random(seed);
      c = v[9:0];
      m.send(c);
      st();
      cmp("rx ready", 32'h1, {31'h0, q[0]});
      wb(1'b0, usart_regs_pkg::OFF_RX_HOLDING, 32'h0);
      cmp("rx word", {16'h0, c.cmd, 6'h0, c.data}, q);
      st();
      cmp("rx clear", 32'h0, {31'h0, q[0]});
    end
    $display("receive test done");
    m.busy_cycles = 40;
    wb(1'b1, usart_regs_pkg::OFF_TX_GUARD, 32'h0);
    for (int i = 0; i < 2; i++) begin
      v = ($random(seed) & 32'h1ff) | {16'h0, i[0], 15'h0};
      txq.push_back(v);
      wb(1'b1, usart_regs_pkg::OFF_TX_HOLDING, v);
    end
    st();
    cmp("tx waiting", 32'h0, {31'h0, q[1]});
    while (m.sent_q.size() < 2) @(posedge clk_i);
    st();
    cmp("tx free", 32'h1, {31'h0, q[1]});
    for (int i = 0; i < 2; i++)
      cmp("tx char", {txq[i][15], txq[i][8:0]}, m.sent_q[i]);
    $display("transmit test done");
    wb(1'b1, usart_regs_pkg::OFF_ISO_RATIO, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, usart_regs_pkg::OFF_MODE, md[i]);
      wb(1'b1, usart_regs_pkg::OFF_BAUD_DIV, dv[i]);
      per();
      per();
      cmpn("bit period", ex[i], p);
    end
    wb(1'b1, usart_regs_pkg::OFF_ISO_RATIO, 32'h0);
    nticks();
    cmpn("iso ratio zero", 0, k);
    wb(1'b1, usart_regs_pkg::OFF_MODE, 32'h0);
    wb(1'b1, usart_regs_pkg::OFF_BAUD_DIV, 32'h0);
    nticks();
    cmpn("divisor zero", 0, k);
    $display("baud test done");
    wb(1'b1, usart_regs_pkg::OFF_MODE, 32'h1);
    wb(1'b1, usart_regs_pkg::OFF_BAUD_DIV, 32'h4);
    v = 2 + ($unsigned($random(seed)) % 4);
    wb(1'b1, usart_regs_pkg::OFF_RX_TIMEOUT, v);
    wb(1'b1, usart_regs_pkg::OFF_CONTROL, 32'h1);
    k = int'(bit_tick_o === 1'b1); // a tick at the ack edge counts too
    while (timeout_o !== 1'b1) begin
      @(posedge clk_i);
      if (bit_tick_o === 1'b1) k++;
    end
    cmpn("timeout ticks", v, k);
    st();
    cmp("timeout flag", 32'h1, {31'h0, q[8]});
    wb(1'b1, usart_regs_pkg::OFF_RX_TIMEOUT, 32'h0);
    wb(1'b1, usart_regs_pkg::OFF_CONTROL, 32'h1);
    k = 0;
    repeat (100) begin
      @(posedge clk_i);
      if (timeout_o !== 1'b0) k++;
    end
    cmpn("timeout off", 0, k);
    $display("timeout test done");
    m.busy_cycles = 2;
    v = 2 + ($unsigned($random(seed)) % 4);
    wb(1'b1, usart_regs_pkg::OFF_TX_GUARD, v);
    wb(1'b1, usart_regs_pkg::OFF_TX_HOLDING, 32'h0000_00a5);
    wb(1'b1, usart_regs_pkg::OFF_TX_HOLDING, 32'h0000_815a);
    while (m.sent_q.size() < 4) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    cmp("tx char", 32'h35a, m.sent_q[3]);
    cmpn("guard gap", 1, int'(gap >= v && gap <= v + 1));
    $display("guard test done");
    finish_test();
  end
endmodule

// ==== testbench/usart_regs_asserts.sv ====
/* checker for the serial port register block: bus answer, ticks, data.
   assumes it is bound into the block and sees only its ports. */
module usart_regs_asserts (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  cyc_i,
  input wire logic                  stb_i,
  input wire logic                  we_i,
  input wire logic [7:0]            adr_i,
  input wire logic [31:0]           dat_i,
  input wire logic [31:0]           dat_o,
  input wire logic                  ack_o,
  input wire logic                  cts_i,
  input wire logic                  tx_load_o,
  input wire usart_regs_pkg::char_t tx_char_o,
  input wire logic                  sample_tick_o,
  input wire logic                  bit_tick_o,
  input wire logic                  timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // new request taken this edge
  logic req;
  assign req = cyc_i && stb_i && !ack_o;
  chk_ack_answer: assert property (req |=> ack_o)
    else $error("request not answered next cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_dat_hold: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved without ack");
  chk_unmapped_zero: assert property (
    $past(req && !we_i && adr_i == 8'h24) && ack_o |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_cts_image: assert property (
    $past(req && !we_i && adr_i == usart_regs_pkg::OFF_STATUS) && ack_o
    |-> dat_o[usart_regs_pkg::ST_CTS_BIT] == $past(cts_i, 2))
    else $error("status cts bit wrong");
  chk_load_pulse: assert property (tx_load_o |=> !tx_load_o)
    else $error("load pulse too long");
  chk_char_hold: assert property (!tx_load_o |-> $stable(tx_char_o))
    else $error("outgoing char moved without load");
  chk_bit_sample: assert property (bit_tick_o |-> sample_tick_o)
    else $error("bit tick without sample tick");
  chk_tout_restart: assert property (
    req && we_i && adr_i == usart_regs_pkg::OFF_CONTROL && dat_i[0]
    |-> ##[1:2] !timeout_o)
    else $error("time-out flag not cleared by restart");
endmodule

bind usart_char_baud_timing_regs usart_regs_asserts chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .cts_i(cts_i), .tx_load_o(tx_load_o),
  .tx_char_o(tx_char_o), .sample_tick_o(sample_tick_o),
  .bit_tick_o(bit_tick_o), .timeout_o(timeout_o));
